/* pkg/frontend_cfg.svh */
`ifndef FRONTEND_CFG_SVH
`define FRONTEND_CFG_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL      5'h00
`define ADDR_CONV_CFG     5'h07
`define ADDR_TEST_MODE    5'h0D
`define ADDR_RX_BIAS      5'h13

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_SOFT_RESET   5
`define CONV_LOW_POWER    4
`define TEST_ANALOG_LOOP  7
`define TEST_DIGITAL_LOOP 6
`define TEST_RX_TRISTATE  5
`define BIAS_CONT_MSB     7
`define BIAS_CONT_LSB     5
`define BIAS_SW_MSB       4
`define BIAS_SW_LSB       3
`define BIAS_CONV_MSB     2
`define BIAS_CONV_LSB     0
`define CMD_READ          6
`define CMD_ADDR_MSB      4

// ----------------------------------------------------------------
// Reset and default values
// ----------------------------------------------------------------
`define RX_BIAS_RESET     8'h00
`define TEST_MODE_RESET   8'h00
`define CONV_CFG_RESET    8'h00
`define CONV_CFG_LOWPWR   8'h10
`define CONV_LOWPWR_CODE  3'h3

// ----------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------
`define BYTE_LAST         3'h7

`endif

/* pkg/frontend_pkg.sv */
`default_nettype none

package frontend_pkg;

    // ------------------------------------------------------------
    // Serial control port states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_CMD  = 3'b010,
        SP_DATA = 3'b100
    } sp_state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] continuous_gain_amp;
        logic [1:0] switched_cap_gain_amp;
        logic [2:0] converter;
    } bias_t;

    typedef struct packed {
        logic full_duplex;
        logic config_high;
    } strap_t;

endpackage

`default_nettype wire

/* rtl/frontend_reset_bias_test_ctrl.sv */
// What this block does
// - Receive bias register splits into three fields.
// - Receive bias register resets to all zeros.
// - Converter low-power bit forces converter bias 011.
// - Duplex strap low half, high full duplex.
// - Register defaults come from both strap pins.
// - Serial select held high disables serial port.
// - Hardware or software reset restores strap defaults.
// - Calibration starts after hardware reset only.
// - Resets never flush transmit interpolation filter.
// - Registers reset immediately when reset pin falls.
// - Calibration starts on reset pin release.
// - Analog loopback feeds converter into transmit path.
// - Digital loopback returns transmit port to receive, in full duplex only.
// - Receive port can be placed in high impedance.
// - Test register bits: analog, digital, three-state.
`include "frontend_cfg.svh"

`default_nettype none

module frontend_reset_bias_test_ctrl #(
    parameter int CONV_W = 12,
    parameter int PORT_W = 6
) (
    input  wire logic                 clk_sys,
    input  wire logic                 arst_n,
    input  wire logic                 duplex_strap,
    input  wire logic                 config_strap,
    input  wire logic                 serial_port_select_n,
    input  wire logic                 serial_clk,
    input  wire logic                 serial_data_in,
    output logic                      serial_data_out,
    output logic                      serial_data_oe,
    input  wire logic [CONV_W-1:0]    adc_data,
    input  wire logic [CONV_W-1:0]    tx_word,
    input  wire logic [PORT_W-1:0]    tx_port,
    input  wire logic [PORT_W-1:0]    rx_word,
    output logic [CONV_W-1:0]         tx_filter_data,
    output logic [PORT_W-1:0]         rx_port_out,
    output logic                      rx_port_oe,
    output frontend_pkg::strap_t      strap,
    output frontend_pkg::bias_t       bias,
    output logic                      cal_start
);
    import frontend_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sp_state_t   state;
    logic        sclk_prev;
    logic        sclk_rise;
    logic        sclk_fall;
    logic [2:0]  bit_cnt;
    logic [7:0]  shift_in;
    logic [7:0]  shift_out;
    logic [7:0]  wr_byte;
    logic        is_read;
    logic [4:0]  addr;
    logic        commit;
    logic        cmd_done;
    logic [7:0]  read_value;
    logic        hw_first;
    logic        soft_req;
    logic        load_defaults;
    logic [7:0]  conv_cfg;
    logic [7:0]  test_mode;
    logic [7:0]  rx_bias;
    logic [7:0]  next_conv_cfg;
    logic        analog_loop;
    logic        digital_loop;
    logic        rx_tristate;

    // ------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------

    // The registers fall to fixed values the moment the pin goes
    // low; strap levels may not enter an async reset, so the
    // strap-dependent defaults land on the first edge after release.
    // immediate register reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hw_first <= 1'b1;
        end else begin
            hw_first <= 1'b0;
        end
    end

    assign load_defaults = hw_first | soft_req;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cal_start <= 1'b0;
        end else begin
            cal_start <= hw_first;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            soft_req <= 1'b0;
        end else if (soft_req) begin
            soft_req <= 1'b0;
        end else if (commit && addr == `ADDR_CONTROL) begin
            soft_req <= wr_byte[`CTRL_SOFT_RESET];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap <= '0;
        end else if (load_defaults) begin
            strap.full_duplex <= duplex_strap;
            strap.config_high <= config_strap;
        end
    end

    always_comb begin
        next_conv_cfg = `CONV_CFG_RESET;
        if (!duplex_strap && config_strap) begin
            next_conv_cfg = `CONV_CFG_LOWPWR;
        end
    end

    // ------------------------------------------------------------
    // Serial control port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= serial_clk;
        end
    end

    assign sclk_rise = serial_clk & ~sclk_prev;
    assign sclk_fall = ~serial_clk & sclk_prev;
    assign cmd_done  = state == SP_CMD && sclk_rise
                       && bit_cnt == `BYTE_LAST;
    assign commit    = state == SP_DATA && sclk_rise && !is_read
                       && bit_cnt == `BYTE_LAST;
    // The last data bit is still on the pin at the commit edge.
    assign wr_byte   = {shift_in[6:0], serial_data_in};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state   <= SP_IDLE;
            bit_cnt <= 3'h0;
        end else if (serial_port_select_n) begin
            state   <= SP_IDLE;
            bit_cnt <= 3'h0;
        end else begin
            unique case (state)
                SP_IDLE: begin
                    state   <= SP_CMD;
                    bit_cnt <= 3'h0;
                end
                SP_CMD: begin
                    if (sclk_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    if (cmd_done) begin
                        state <= SP_DATA;
                    end
                end
                SP_DATA: begin
                    if (sclk_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    if (sclk_rise && bit_cnt == `BYTE_LAST) begin
                        state <= SP_CMD;
                    end
                end
                default: begin
                    state <= SP_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_in <= 8'h00;
        end else if (sclk_rise && state != SP_IDLE
                     && !serial_port_select_n) begin
            shift_in <= {shift_in[6:0], serial_data_in};
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            is_read <= 1'b0;
            addr    <= 5'h00;
        end else if (cmd_done) begin
            is_read <= shift_in[`CMD_READ - 1];
            addr    <= {shift_in[3:0], serial_data_in};
        end
    end

    always_comb begin
        unique case (addr)
            `ADDR_CONV_CFG:  read_value = conv_cfg;
            `ADDR_TEST_MODE: read_value = test_mode;
            `ADDR_RX_BIAS:   read_value = rx_bias;
            default:         read_value = 8'h00;
        endcase
    end

    // Read data is loaded on the fall that closes the command byte,
    // once the address has settled, and then shifts on each later
    // fall, so the host can sample it before the next rise.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_out <= 8'h00;
        end else if (state == SP_DATA && is_read && sclk_fall) begin
            if (bit_cnt == 3'h0) begin
                shift_out <= read_value;
            end else begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
        end else begin
            serial_data_out <= shift_out[7];
            serial_data_oe  <= state == SP_DATA && is_read
                               && !serial_port_select_n;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            conv_cfg <= `CONV_CFG_RESET;
        end else if (load_defaults) begin
            conv_cfg <= next_conv_cfg;
        end else if (commit && addr == `ADDR_CONV_CFG) begin
            conv_cfg <= wr_byte;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            test_mode <= `TEST_MODE_RESET;
        end else if (load_defaults) begin
            test_mode <= `TEST_MODE_RESET;
        end else if (commit && addr == `ADDR_TEST_MODE) begin
            test_mode <= wr_byte;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_bias <= `RX_BIAS_RESET;
        end else if (load_defaults) begin
            rx_bias <= `RX_BIAS_RESET;
        end else if (commit && addr == `ADDR_RX_BIAS) begin
            rx_bias <= wr_byte;
        end
    end

    // ------------------------------------------------------------
    // Bias outputs
    // ------------------------------------------------------------

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bias <= '0;
        end else begin
            bias.continuous_gain_amp <=
                rx_bias[`BIAS_CONT_MSB:`BIAS_CONT_LSB];
            bias.switched_cap_gain_amp <=
                rx_bias[`BIAS_SW_MSB:`BIAS_SW_LSB];
            if (conv_cfg[`CONV_LOW_POWER]) begin
                bias.converter <= `CONV_LOWPWR_CODE;
            end else begin
                bias.converter <=
                    rx_bias[`BIAS_CONV_MSB:`BIAS_CONV_LSB];
            end
        end
    end

    // ------------------------------------------------------------
    // Test data paths
    // ------------------------------------------------------------
    assign analog_loop  = test_mode[`TEST_ANALOG_LOOP];
    assign digital_loop = test_mode[`TEST_DIGITAL_LOOP];
    assign rx_tristate  = test_mode[`TEST_RX_TRISTATE];

    // The filter input register is cleared only by the pin reset so
    // the output is defined; the filter history downstream is not
    // flushed, which the host must do separately.
    // no filter flush
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_filter_data <= '0;
        end else if (analog_loop) begin
            tx_filter_data <= adc_data;
        end else begin
            tx_filter_data <= tx_word;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_port_out <= '0;
        end else if (digital_loop && strap.full_duplex) begin
            rx_port_out <= tx_port;
        end else begin
            rx_port_out <= rx_word;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_port_oe <= 1'b0;
        end else begin
            rx_port_oe <= !rx_tristate;
        end
    end

endmodule

`default_nettype wire

/* verification/frontend_monitor.sv */
`default_nettype none
module frontend_monitor #(
    parameter int CONV_W = 12,
    parameter int PORT_W = 6
) (
    input wire logic                 clk_sys,
    input wire logic                 arst_n,
    input wire logic                 duplex_strap,
    input wire logic                 config_strap,
    input wire logic                 serial_port_select_n,
    input wire logic                 serial_data_oe,
    input wire logic [CONV_W-1:0]    adc_data,
    input wire logic [CONV_W-1:0]    tx_word,
    input wire logic [PORT_W-1:0]    tx_port,
    input wire logic [PORT_W-1:0]    rx_word,
    input wire logic [CONV_W-1:0]    tx_filter_data,
    input wire logic [PORT_W-1:0]    rx_port_out,
    input wire logic                 rx_port_oe,
    input wire frontend_pkg::strap_t strap,
    input wire frontend_pkg::bias_t  bias,
    input wire logic                 cal_start
);
    timeunit 1ns;
    timeprecision 1ps;
    import frontend_pkg::*;
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_cal_single: assert property (
        cal_start |=> !cal_start) else $error("cal pulse too long");
    chk_cal_hw_only: assert property (
        cal_start |-> $past(arst_n) && !$past(arst_n, 2))
        else $error("cal pulse not after reset release");
    chk_strap_follow: assert property (
        $past(arst_n, 2) |->
        strap == {$past(duplex_strap), $past(config_strap)})
        else $error("strap capture wrong");
    chk_bias_clear: assert property (
        !$past(arst_n) |-> bias == 8'h00) else $error("bias not clear");
    chk_tx_mux: assert property (
        $past(arst_n) |-> tx_filter_data == $past(adc_data) ||
        tx_filter_data == $past(tx_word)) else $error("tx path bad");
    chk_rx_loop: assert property (
        $past(arst_n) && rx_port_oe && rx_port_out != $past(rx_word)
        |-> rx_port_out == $past(tx_port) && $past(strap.full_duplex))
        else $error("rx loop bad");
    chk_oe_idle: assert property (
        serial_port_select_n && $past(serial_port_select_n)
        |-> !serial_data_oe) else $error("read drive while idle");
    chk_bias_hold: assert property (
        serial_port_select_n [*3] ##0 $past(arst_n, 3) |-> $stable(bias))
        else $error("bias moved without a frame");
    cover property (cal_start);
    cover property ($rose(serial_data_oe));
    cover property (!rx_port_oe);
endmodule
bind frontend_reset_bias_test_ctrl frontend_monitor #(
    .CONV_W(CONV_W), .PORT_W(PORT_W)) u_mon (.*);
`default_nettype wire

/* verification/serial_host.sv */
`default_nettype none
module serial_host (
    input  wire logic clk_sys,
    input  wire logic sdo,
    output logic      sel_n,
    output logic      sclk,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Host side of the serial control port
    // ------------------------------------------------------------
    initial begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        sdi   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Clock stands low between frames; the low phase length sets pace.
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                        input logic hold, input int lo,
                        output logic [7:0] rd);
        logic [15:0] word;
        word  = {cmd, wd};
        sel_n = hold;
        tick(2);
        for (int i = 15; i >= 0; i--) begin
            sdi = word[i];
            tick(lo);
            if (i < 8) rd[i] = sdo;
            sclk = 1'b1;
            tick(2);
            sclk = 1'b0;
        end
        tick(3);
        sel_n = 1'b1;
        sdi   = ~sdi;
        tick(2);
    endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_sys = 1'b0;
    logic                 arst_n = 1'b0;
    logic                 duplex_strap = 1'b1;
    logic                 config_strap = 1'b1;
    logic                 sel_n;
    logic                 sclk;
    logic                 sdi;
    logic                 sdo_raw;
    logic                 sdo_oe;
    logic                 sdo;
    // Converter words stay well inside full scale.
    logic [11:0]          adc_data = 12'h3A5;
    logic [11:0]          tx_word = 12'h5C3;
    logic [11:0]          tx_filter_data;
    logic [5:0]           tx_port = 6'h2A;
    logic [5:0]           rx_word = 6'h15;
    logic [5:0]           rx_port_out;
    logic                 rx_oe;
    logic                 cal_start;
    frontend_pkg::strap_t strap;
    frontend_pkg::bias_t  bias;
    logic [7:0]           rd_v;
    int                   miscompares = 0;
    int                   num_checks = 0;
    int                   cycles = 0;
    int                   cal_cnt = 0;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    always #25 clk_sys = ~clk_sys;
    assign sdo = sdo_oe ? sdo_raw : ~sdo_raw;
    frontend_reset_bias_test_ctrl DUT (
        .clk_sys(clk_sys), .arst_n(arst_n), .duplex_strap(duplex_strap),
        .config_strap(config_strap), .serial_port_select_n(sel_n),
        .serial_clk(sclk), .serial_data_in(sdi),
        .serial_data_out(sdo_raw), .serial_data_oe(sdo_oe),
        .adc_data(adc_data), .tx_word(tx_word), .tx_port(tx_port),
        .rx_word(rx_word), .tx_filter_data(tx_filter_data),
        .rx_port_out(rx_port_out), .rx_port_oe(rx_oe), .strap(strap),
        .bias(bias), .cal_start(cal_start));
    serial_host u_host (.clk_sys(clk_sys), .sdo(sdo), .sel_n(sel_n),
                        .sclk(sclk), .sdi(sdi));
    always @(posedge clk_sys) begin
        cycles++;
        if (cal_start === 1'b1) cal_cnt++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // The power-up hold is shortened; the block has no power-up timer.
    task automatic hw_reset(input logic d, input logic c);
        @(posedge clk_sys);
        #1;
        arst_n = 1'b0;
        duplex_strap = d;
        config_strap = c;
        repeat (2) @(posedge clk_sys);
        #1;
        cal_cnt = 0;
        arst_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.xfer(a, d, 1'b0, 3, rd_v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.xfer(8'h40 | a, 8'h5A, 1'b0, 6, rd_v);
        check(rd_v, exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            hw_reset(i[1], i[0]);
            check(strap, i[1:0]);
            check(bias, (!i[1] && i[0]) ? 12'h3 : 12'h0);
            check(cal_cnt, 1);
        end
        $display("straps test done");
    endtask
    task automatic t_bias();
        wr(8'h13, 8'hB5);
        check(bias, 12'hB5);
        rd(8'h13, 8'hB5);
        wr(8'h07, 8'h10);
        check(bias, 12'hB3);
        wr(8'h07, 8'h00);
        check(bias, 12'hB5);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        $display("bias test done");
    endtask
    task automatic t_test();
        logic [7:0] m [4] = '{8'h00, 8'h80, 8'h40, 8'h20};
        for (int i = 0; i < 4; i++) begin
            wr(8'h0D, m[i]);
            check(tx_filter_data, m[i][7] ? adc_data : tx_word);
            check(rx_port_out, m[i][6] ? tx_port : rx_word);
            check(rx_oe, !m[i][5]);
        end
        rd(8'h0D, 8'h20);
        hw_reset(1'b0, 1'b0);
        wr(8'h0D, 8'hC0);
        check(rx_port_out, rx_word);
        check(tx_filter_data, adc_data);
        $display("test mode test done");
    endtask
    task automatic t_soft();
        hw_reset(1'b0, 1'b1);
        wr(8'h13, 8'hB5);
        wr(8'h0D, 8'h80);
        cal_cnt = 0;
        wr(8'h00, 8'h20);
        check(bias, 12'h3);
        check(tx_filter_data, tx_word);
        check(strap, 12'h1);
        check(cal_cnt, 0);
        rd(8'h00, 8'h00);
        u_host.xfer(8'h13, 8'hFF, 1'b1, 3, rd_v);
        check(bias, 12'h3);
        wr(8'h13, 8'hB5);
        check(bias, 12'hB3);
        $display("soft reset test done");
    endtask
    task automatic t_async();
        wr(8'h0D, 8'h80);
        arst_n = 1'b0;
        #5;
        check(tx_filter_data, 12'h0);
        check(bias, 12'h0);
        check(rx_oe, 1'b0);
        hw_reset(1'b1, 1'b1);
        check(cal_cnt, 1);
        $display("async reset test done");
    endtask
    initial begin
        t_straps();
        t_bias();
        t_test();
        t_soft();
        t_async();
        end_of_test();
    end
endmodule
`default_nettype wire
